/* File: rtl/idmac_pkg.sv */
// Package for the DMA channel programming register block.
// Assumes an 8-bit I/O window with a 4-bit register offset.
package idmac_pkg;

  // I/O offsets within the window.
  localparam logic [3:0] OFS_SW_REQ      = 4'h9;
  localparam logic [3:0] OFS_SINGLE_MASK = 4'ha;
  localparam logic [3:0] OFS_MODE        = 4'hb;
  localparam logic [3:0] OFS_BP_CLEAR    = 4'hc;
  localparam logic [3:0] OFS_TEMP_MCLR   = 4'hd;
  localparam logic [3:0] OFS_UNMASK_ALL  = 4'he;
  localparam logic [3:0] OFS_MULTI_MASK  = 4'hf;

  // Field positions shared by request, single mask and mode writes.
  localparam int SEL_LSB     = 0;
  localparam int SET_OR_CLEAR_BIT = 2;
  localparam int TTYPE_LSB   = 2;
  localparam int AUTOINIT_BIT = 4;
  localparam int DIR_BIT     = 5;
  localparam int MODE_LSB    = 6;

  // Reset values.
  localparam logic [3:0] MASK_RST  = 4'hf;
  localparam logic [3:0] REQ_RST   = 4'h0;
  localparam logic [7:0] TEMP_RST  = 8'h00;

  typedef enum logic [1:0] {
    IDMAC_DEMAND  = 2'h0,
    IDMAC_SINGLE  = 2'h1,
    IDMAC_BLOCK   = 2'h2,
    IDMAC_CASCADE = 2'h3
  } idmac_xfer_mode_t;

  typedef enum logic [1:0] {
    IDMAC_VERIFY  = 2'h0,
    IDMAC_WRITE   = 2'h1,
    IDMAC_READ    = 2'h2,
    IDMAC_ILLEGAL = 2'h3
  } idmac_ttype_t;

  // Per-channel mode as stored.
  typedef struct packed {
    idmac_xfer_mode_t mode;
    logic             address_direction;
    logic             auto_init;
    idmac_ttype_t     transfer_type_field;
  } idmac_chan_mode_t;

  localparam idmac_chan_mode_t MODE_RST = '{IDMAC_DEMAND, 1'b0, 1'b0, IDMAC_VERIFY};

  // Register access strobe group from the I/O window.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } idmac_io_t;

endpackage : idmac_pkg

/* File: rtl/idmac_chan.sv */
// One channel's programmable state: request, mask and mode.
// Assumes decoded, one-cycle write strobes from the register block.
`timescale 1ns/100ps
`default_nettype none
module idmac_chan
  import idmac_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             clr,
  input  wire logic             req_wr,
  input  wire logic             smask_wr,
  input  wire logic             mode_wr,
  input  wire logic             unmask_all,
  input  wire logic             mmask_wr,
  input  wire logic             mmask_bit,
  input  wire logic             set_or_clear_bit,
  input  wire logic             mem_copy,
  input  wire logic [7:0]       wdata,
  output logic                  req_ff,
  output logic                  mask_ff,
  output idmac_chan_mode_t      mode_ff
);

  logic             nxt_req;
  logic             nxt_mask;
  idmac_chan_mode_t nxt_mode;
  idmac_chan_mode_t wr_mode;

  // Transfer type is a don't care under cascade or memory copy, so keep old value.
  assign wr_mode.mode                = idmac_xfer_mode_t'(wdata[MODE_LSB +: 2]);
  assign wr_mode.address_direction   = wdata[DIR_BIT];
  assign wr_mode.auto_init           = wdata[AUTOINIT_BIT];
  assign wr_mode.transfer_type_field =
    ((wdata[MODE_LSB +: 2] == IDMAC_CASCADE) || mem_copy) ?
    mode_ff.transfer_type_field : idmac_ttype_t'(wdata[TTYPE_LSB +: 2]);

  // Software request set or clear.
  assign nxt_req  = req_wr ? set_or_clear_bit : req_ff;
  // Unmask-all beats the others; the writes are to distinct offsets anyway.
  assign nxt_mask = unmask_all ? 1'b0 :
                    mmask_wr   ? mmask_bit :
                    smask_wr   ? set_or_clear_bit : mask_ff;
  assign nxt_mode = mode_wr ? wr_mode : mode_ff;

  // State registers; clr covers both hardware and master clear.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      req_ff  <= REQ_RST[0];
      mask_ff <= MASK_RST[0];
      mode_ff <= MODE_RST;
    end else begin
      req_ff  <= nxt_req;
      mask_ff <= nxt_mask;
      mode_ff <= nxt_mode;
    end
  end

endmodule : idmac_chan
`default_nettype wire

/* File: rtl/idmac_regs.sv */
// Register block for DMA channel programming: request, mask, mode, byte pointer,
// temporary byte and master clear. Assumes a same-clock I/O window that gives
// one-cycle rd/wr strobes; memory-copy bytes arrive from the transfer engine.
`timescale 1ns/100ps
`default_nettype none
module idmac_regs
  import idmac_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire idmac_io_t        io,
  input  wire logic             memory_copy_enable,
  input  wire logic             addr_cnt_access,
  input  wire logic             copy_byte_vld,
  input  wire logic [7:0]       copy_byte,
  output logic [7:0]            rdata_ff,
  output logic                  rvalid_ff,
  output logic                  byte_pointer_flipflop,
  output logic [3:0]            dreq_sw_ff,
  output logic [3:0]            chan_mask_ff,
  output idmac_chan_mode_t      chan_mode_ff [4],
  output logic                  software_master_reset_ff
);

  // Decoded one-cycle strobes, one per register.
  logic       wr_req;
  logic       wr_smask;
  logic       wr_mode;
  logic       wr_bpclr;
  logic       wr_mclr;
  logic       wr_unmask;
  logic       wr_mmask;
  logic       rd_temp;
  // Channel select, shared clear and the local state.
  logic [3:0] sel_dec;
  logic       clr;
  logic       bp_ff;
  logic       nxt_bp;
  logic [7:0] temp_ff;
  logic [7:0] nxt_temp;
  logic [7:0] nxt_rdata;

  // Offset decode of write and read strobes.
  assign wr_req    = io.wr && (io.addr == OFS_SW_REQ);
  assign wr_smask  = io.wr && (io.addr == OFS_SINGLE_MASK);
  assign wr_mode   = io.wr && (io.addr == OFS_MODE);
  assign wr_bpclr  = io.wr && (io.addr == OFS_BP_CLEAR);
  assign wr_mclr   = io.wr && (io.addr == OFS_TEMP_MCLR);
  assign wr_unmask = io.wr && (io.addr == OFS_UNMASK_ALL);
  assign wr_mmask  = io.wr && (io.addr == OFS_MULTI_MASK);
  assign rd_temp   = io.rd && (io.addr == OFS_TEMP_MCLR);

  // Binary channel selector, one-hot per channel.
  assign sel_dec = 4'h1 << io.wdata[SEL_LSB +: 2];

  // Master clear resets the channels, pointer and temporary byte the next edge, as hardware reset does.
  assign clr = rst || wr_mclr;

  // Four identical channel slices.
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      idmac_chan u_chan (
        .ref_clk          (ref_clk),
        .clr              (clr),
        .req_wr           (wr_req && sel_dec[g]),
        .smask_wr         (wr_smask && sel_dec[g]),
        .mode_wr          (wr_mode && sel_dec[g]),
        .unmask_all       (wr_unmask),
        .mmask_wr         (wr_mmask),
        .mmask_bit        (io.wdata[g]),
        .set_or_clear_bit (io.wdata[SET_OR_CLEAR_BIT]),
        .mem_copy         (memory_copy_enable),
        .wdata            (io.wdata),
        .req_ff           (dreq_sw_ff[g]),
        .mask_ff          (chan_mask_ff[g]),
        .mode_ff          (chan_mode_ff[g])
      );
    end
  endgenerate

  // Pointer toggles per address/count access; a clear write wins. Software is
  // expected to clear it first so the low byte comes first.
  assign nxt_bp   = wr_bpclr ? 1'b0 : (addr_cnt_access ? ~bp_ff : bp_ff);
  assign nxt_temp = copy_byte_vld ? copy_byte : temp_ff;
  assign nxt_rdata = rd_temp ? temp_ff : 8'h00;
  assign byte_pointer_flipflop = bp_ff;

  // Pointer and temporary byte.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      bp_ff   <= 1'b0;
      temp_ff <= TEMP_RST;
    end else begin
      bp_ff   <= nxt_bp;
      temp_ff <= nxt_temp;
    end
  end

  // Read data and the one-cycle reset pulse to the rest of the controller.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff                 <= 8'h00;
      rvalid_ff                <= 1'b0;
      software_master_reset_ff <= 1'b0;
    end else begin
      rdata_ff                 <= nxt_rdata;
      rvalid_ff                <= io.rd;
      software_master_reset_ff <= wr_mclr;
    end
  end

  // Checks beside the logic. Field positions come from the package so the
  // checks follow the register layout instead of restating it.
  a_req_set_path: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_req && !wr_mclr) |=> dreq_sw_ff[$past(io.wdata[SEL_LSB +: 2])] == $past(io.wdata[SET_OR_CLEAR_BIT]))
    else $error("software request not applied");
  a_sel_decode: assert property (@(posedge ref_clk) disable iff (rst)
    wr_smask |-> $onehot(sel_dec) && sel_dec[io.wdata[SEL_LSB +: 2]])
    else $error("selector decode not one-hot");
  a_single_mask: assert property (@(posedge ref_clk) disable iff (rst)
    wr_smask |=> chan_mask_ff[$past(io.wdata[SEL_LSB +: 2])] == $past(io.wdata[SET_OR_CLEAR_BIT]))
    else $error("single mask not applied");
  a_mode_store: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mode |=> chan_mode_ff[$past(io.wdata[SEL_LSB +: 2])].mode == $past(io.wdata[MODE_LSB +: 2]))
    else $error("mode field not stored");
  a_dir_store: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mode |=> chan_mode_ff[$past(io.wdata[SEL_LSB +: 2])].address_direction == $past(io.wdata[DIR_BIT]))
    else $error("direction not stored");
  a_type_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_mode && memory_copy_enable) |=> chan_mode_ff[$past(io.wdata[SEL_LSB +: 2])].transfer_type_field ==
      $past(chan_mode_ff[io.wdata[SEL_LSB +: 2]].transfer_type_field))
    else $error("type changed under memory copy");

  // Byte pointer: clear, toggle and hold.
  a_bp_clear: assert property (@(posedge ref_clk) disable iff (rst)
    wr_bpclr |=> !byte_pointer_flipflop)
    else $error("byte pointer not cleared");
  a_bp_toggle: assert property (@(posedge ref_clk) disable iff (rst)
    (addr_cnt_access && !wr_bpclr && !wr_mclr) |=> byte_pointer_flipflop != $past(byte_pointer_flipflop))
    else $error("byte pointer did not toggle");
  a_bp_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!addr_cnt_access && !wr_bpclr && !wr_mclr) |=> $stable(byte_pointer_flipflop))
    else $error("byte pointer moved without access");

  // Temporary byte capture and the read path.
  a_temp_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (copy_byte_vld && !wr_mclr) |=> temp_ff == $past(copy_byte))
    else $error("copied byte not captured");
  a_temp_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!copy_byte_vld && !wr_mclr) |=> $stable(temp_ff))
    else $error("temporary byte changed");
  a_temp_read: assert property (@(posedge ref_clk) disable iff (rst)
    rd_temp |=> rvalid_ff && (rdata_ff == $past(temp_ff)))
    else $error("temporary byte wrong");
  a_unmapped_read: assert property (@(posedge ref_clk) disable iff (rst)
    (io.rd && !rd_temp) |=> rdata_ff == 8'h00)
    else $error("other offset read not zero");
  a_rvalid_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    io.rd |=> rvalid_ff)
    else $error("read valid missing");

  // Master clear behaves as a reset and raises its pulse for one cycle.
  a_master_clr: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mclr |=> (chan_mask_ff == MASK_RST) && (dreq_sw_ff == REQ_RST) && !byte_pointer_flipflop &&
      (temp_ff == TEMP_RST))
    else $error("master clear incomplete");
  a_reset_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mclr |=> software_master_reset_ff)
    else $error("reset pulse missing");
  a_no_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    !wr_mclr |=> !software_master_reset_ff)
    else $error("reset pulse without clear");

  // Whole-mask writes.
  a_unmask_all: assert property (@(posedge ref_clk) disable iff (rst)
    wr_unmask |=> chan_mask_ff == 4'h0)
    else $error("masks not all cleared");
  a_multi_mask: assert property (@(posedge ref_clk) disable iff (rst)
    wr_mmask |=> chan_mask_ff == $past(io.wdata[3:0]))
    else $error("multi mask not loaded");

  // Checked per channel so that no sampled-value call needs an index that is
  // itself a sampled value, which some tools refuse.
  generate
    for (g = 0; g < 4; g++) begin : g_mode_chk
      a_type_stored: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_mode && sel_dec[g] && !memory_copy_enable && (io.wdata[MODE_LSB +: 2] != IDMAC_CASCADE)) |=>
          chan_mode_ff[g].transfer_type_field == $past(io.wdata[TTYPE_LSB +: 2]))
        else $error("transfer type not stored");
      a_type_cascade: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_mode && sel_dec[g] && (io.wdata[MODE_LSB +: 2] == IDMAC_CASCADE)) |=>
          $stable(chan_mode_ff[g].transfer_type_field))
        else $error("type changed under cascade");
      a_auto_init: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_mode && sel_dec[g]) |=> chan_mode_ff[g].auto_init == $past(io.wdata[AUTOINIT_BIT]))
        else $error("auto-initialisation not stored");
      a_other_chan: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_mode && !sel_dec[g]) |=> $stable(chan_mode_ff[g]))
        else $error("unselected mode changed");
      a_mask_kept: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_smask && !sel_dec[g]) |=> $stable(chan_mask_ff[g]))
        else $error("unselected mask changed");
      a_req_kept: assert property (@(posedge ref_clk) disable iff (rst)
        (wr_req && !sel_dec[g]) |=> $stable(dreq_sw_ff[g]))
        else $error("unselected request changed");
      a_mclr_mode: assert property (@(posedge ref_clk) disable iff (rst)
        wr_mclr |=> chan_mode_ff[g] == MODE_RST)
        else $error("mode not cleared");
    end
  endgenerate

endmodule : idmac_regs
`default_nettype wire

/* File: tb/idmac_xfer_model.sv */
// Stand-in for the transfer engine: copied bytes and address/count byte pulses.
// Assumes the bench calls its tasks just after a falling edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module idmac_xfer_model (
  input  wire logic  ref_clk,
  output logic       copy_byte_vld,
  output logic [7:0] copy_byte,
  output logic       addr_cnt_access
);
  // Idle outputs at time zero.
  initial begin
    copy_byte_vld   = 1'b0;
    copy_byte       = 8'h00;
    addr_cnt_access = 1'b0;
  end
  // One moved byte; afterwards the data shows its inverse so a stale byte cannot pass.
  task automatic copy(input logic [7:0] b);
    copy_byte_vld = 1'b1;
    copy_byte     = b;
    @(negedge ref_clk);
    copy_byte_vld = 1'b0;
    copy_byte     = ~b;
    // Idle a cycle so back-to-back copies never raise the strobe in the step that lowered it.
    @(negedge ref_clk);
  endtask : copy
  // One address or count byte access, which moves the byte pointer on.
  task automatic touch();
    addr_cnt_access = 1'b1;
    @(negedge ref_clk);
    addr_cnt_access = 1'b0;
  endtask : touch
endmodule : idmac_xfer_model
`default_nettype wire

/* File: tb/test_isa_dma_channel_programming.sv */
// Self-checking bench for the channel programming register block.
// Assumes one-cycle strobes driven at the falling edge; reads are checked from a queue.
`timescale 1ns/100ps
`default_nettype none
module test_isa_dma_channel_programming;
  import idmac_pkg::*;
  logic             ref_clk, rst, mem_copy, vld, acc, rvalid, pulse, bp;
  logic [7:0]       cb, rdata, v;
  logic [3:0]       req, mask;
  idmac_io_t        io;
  idmac_chan_mode_t modes [4];
  idmac_chan_mode_t exp_mode [4];
  logic [7:0]       rq [$];
  int               error_cnt, cmp_count, seed;

  idmac_regs u_dut (.ref_clk(ref_clk), .rst(rst), .io(io), .memory_copy_enable(mem_copy),
    .addr_cnt_access(acc), .copy_byte_vld(vld), .copy_byte(cb), .rdata_ff(rdata), .rvalid_ff(rvalid),
    .byte_pointer_flipflop(bp), .dreq_sw_ff(req), .chan_mask_ff(mask), .chan_mode_ff(modes),
    .software_master_reset_ff(pulse));
  idmac_xfer_model u_xfer (.ref_clk(ref_clk), .copy_byte_vld(vld), .copy_byte(cb), .addr_cnt_access(acc));

  // Clock at 40 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Writes leave an idle cycle so a strobe is never assigned twice in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    io = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    io = '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    io = '{1'b0, 1'b1, a, 8'h00};
    rq.push_back(e);
    @(negedge ref_clk);
    io = '0;
  endtask : rd
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // Read monitor: each valid read takes the oldest expected byte.
  always @(negedge ref_clk) begin
    if (rvalid === 1'b1) begin
      if (rq.size() > 0) chk(rdata, rq.pop_front(), "read data");
      else chk(rdata, 8'hxx, "unexpected read");
    end
  end
  // Watchdog against a hung run.
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    give_verdict();
  end

  initial begin
    seed = 32'hef100b90;
    io = '0;
    mem_copy = 1'b0;
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    chk({4'h0, mask}, 8'h0f, "mask reset");
    chk({4'h0, req}, 8'h00, "request reset");
    for (int c = 0; c < 4; c++) wr(OFS_SW_REQ, {5'($random(seed)), 1'b1, 2'(c)});
    chk({4'h0, req}, 8'h0f, "requests set");
    wr(OFS_SW_REQ, 8'h02);
    chk({4'h0, req}, 8'h0b, "request 2 cleared");
    wr(OFS_SINGLE_MASK, 8'h01);
    wr(OFS_SINGLE_MASK, 8'h03);
    chk({4'h0, mask}, 8'h05, "single clears");
    wr(OFS_SINGLE_MASK, 8'h05);
    chk({4'h0, mask}, 8'h07, "single set");
    wr(OFS_UNMASK_ALL, 8'($random(seed)));
    chk({4'h0, mask}, 8'h00, "unmask all");
    v = 8'($random(seed));
    wr(OFS_MULTI_MASK, v);
    chk({4'h0, mask}, {4'h0, v[3:0]}, "multi mask");
    $display("request and mask tests done");
    // Every mode including cascade and every legal type, with and without memory copy.
    exp_mode = '{default: MODE_RST};
    for (int k = 0; k < 32; k++) begin
      mem_copy = k[0];
      v = {k[4:3], 2'($random(seed)), 2'(k[2:1] % 3), 2'($random(seed))};
      wr(OFS_MODE, v);
      exp_mode[v[1:0]].mode = idmac_xfer_mode_t'(v[7:6]);
      exp_mode[v[1:0]].address_direction = v[5];
      exp_mode[v[1:0]].auto_init = v[4];
      if (v[7:6] != 2'h3 && !mem_copy) exp_mode[v[1:0]].transfer_type_field = idmac_ttype_t'(v[3:2]);
      chk({2'h0, modes[v[1:0]]}, {2'h0, exp_mode[v[1:0]]}, "mode");
    end
    mem_copy = 1'b0;
    $display("mode tests done");
    wr(OFS_BP_CLEAR, 8'($random(seed)));
    chk({7'h0, bp}, 8'h00, "pointer cleared");
    for (int i = 1; i < 4; i++) begin
      u_xfer.touch();
      chk({7'h0, bp}, {7'h0, i[0]}, "pointer toggle");
      @(negedge ref_clk);
    end
    wr(OFS_BP_CLEAR, 8'hff);
    chk({7'h0, bp}, 8'h00, "pointer clear from high");
    // Clear write and a pointer access in one cycle: the clear must win.
    @(negedge ref_clk);
    io = '{1'b1, 1'b0, OFS_BP_CLEAR, 8'($random(seed))};
    u_xfer.touch();
    io = '0;
    chk({7'h0, bp}, 8'h00, "clear beats toggle");
    v = 8'($random(seed));
    u_xfer.copy(~v);
    u_xfer.copy(v);
    rd(OFS_TEMP_MCLR, v);
    rd(4'h3, 8'h00);
    rd(OFS_MODE, 8'h00);
    $display("pointer and temporary byte tests done");
    u_xfer.touch();
    wr(OFS_TEMP_MCLR, 8'($random(seed)));
    chk({7'h0, pulse}, 8'h01, "reset pulse");
    @(negedge ref_clk);
    chk({4'h0, mask}, 8'h0f, "mask after clear");
    chk({4'h0, req}, 8'h00, "request after clear");
    chk({7'h0, bp}, 8'h00, "pointer after clear");
    for (int c = 0; c < 4; c++) chk({2'h0, modes[c]}, {2'h0, MODE_RST}, "mode after clear");
    rd(OFS_TEMP_MCLR, TEMP_RST);
    for (int i = 0; i < 20 && rq.size() > 0; i++) @(negedge ref_clk);
    if (rq.size() > 0) chk(8'h00, 8'h01, "reads missing");
    $display("master clear tests done");
    // Hardware reset in mid-run must restore the reset mask and drop read valid.
    wr(OFS_UNMASK_ALL, 8'h00);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    chk({4'h0, mask}, 8'h0f, "mask after hardware reset");
    chk({7'h0, rvalid}, 8'h00, "read valid after hardware reset");
    $display("hardware reset test done");
    give_verdict();
  end
endmodule : test_isa_dma_channel_programming
`default_nettype wire
